// ---- verilog/epc_manager.sv ----
// Extended power-condition manager: subcommand decode, idle timers, condition moves.
// Assumes an APB master at 10 MHz; firmware reports command events through CTRL.
// Notes on behaviour
// - Feature selector 4Ah carries the extended power-condition subcommands; abort if unsupported.
// - Subcommands 0..5 restore, goto, timer, state, enable, disable; 6..F reserved.
// - Ids 00h,01h standby, 81h..83h idle, FFh all; others reserved.
// - Idle levels report idle state; standby levels report standby state.
// - Conditions ranked active idle down to deep standby by power.
// - Current, saved and default sets; defaults fixed; current lost on power loss.
// - Zero timer disables its condition; never entered by expiry.
// - All enabled timers count from command completion, independently.
// - Command completion reloads every stopped timer of an enabled condition from current and starts it.
// - Expiry moves only to a lower-power condition, else stays.
// - Several eligible at once: take the lowest-power one.
// - Active-requiring command stops timers; other commands leave them running.
// - Flush write cache before a media-inaccessible condition when cache enabled.
// - Power cycle: stop timers, copy saved to current, restart enabled.
// - Resets: stop timers, keep condition, restart enabled from current.
// - Feature disabled: abort all subcommands except enable.
// - Enabling the older scheme with identify word 120 bit 7 disables feature.
// - Background activity pauses timers; they resume from remaining count.
`timescale 1ns/1ps
module epc_manager
	import epc_pkg::*;
#(
	parameter int TICK_CNT = TICK_CYCLES,
	parameter logic [TMR_W-1:0] DEF_TIMER = 32'h0000_0064
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);

	logic             enabled_q;
	logic             abort_q;
	logic             supported_q;
	logic             wcache_q;
	logic [2:0]       cond_q;
	logic [2:0]       target_q;
	logic [31:0]      arg_q;
	logic [2:0]       tsel_q;
	logic             bkg_q;
	logic             id120_q;
	mgr_t             st_q;
	logic [31:0]      tick_cnt_q;
	logic             tick;
	logic [TMR_W-1:0] cur_q   [NCOND];
	logic [TMR_W-1:0] saved_q [NCOND];
	logic [NCOND-1:0] cur_en_q;
	logic [NCOND-1:0] saved_en_q;
	logic [NCOND-1:0] stop_v;
	logic [NCOND-1:0] load_v;
	logic [NCOND-1:0] run_v;
	logic [NCOND-1:0] exp_v;
	logic [TMR_W-1:0] cnt_v   [NCOND];
	logic             wr;
	logic             rd;
	logic             cmd_wr;
	logic [3:0]       sub;
	logic [7:0]       cid;
	logic             cmd_ok;
	logic [31:0]      ctl;
	logic             ev_done;
	logic             ev_act;
	logic             ev_pcyc;
	logic             ev_rst;
	logic             apm_dis;
	logic [2:0]       exp_pick;
	logic             pick_ok;

	// APB slave: zero wait states, unmapped offsets answer with an error
	assign pready = 1'b1;
	assign wr     = psel && penable && pwrite;
	assign rd     = psel && penable && !pwrite;
	assign ctl    = wr && paddr == R_CTRL ? pwdata : 32'h0000_0000;
	assign cmd_wr = wr && paddr == R_CMD;
	assign sub    = pwdata[11:8];
	assign cid    = pwdata[19:12];

	always_comb begin
		unique case (paddr)
			R_CMD, R_ARG, R_CTRL, R_STATUS, R_TSEL, R_TCUR, R_TCNT: pslverr = 1'b0;
			default: pslverr = psel && penable;
		endcase
	end

	// Event strobes from firmware
	assign ev_done = ctl[CT_DONE];
	assign ev_act  = ctl[CT_ACTCMD];
	assign ev_pcyc = ctl[CT_POWERCYC];
	assign ev_rst  = ctl[CT_RESET];
	// older scheme enable wins; word 120 level rides on the same write
	assign apm_dis = ctl[CT_APM_EN] && ctl[CT_ID120];

	always_comb begin
		cmd_ok = cmd_wr && pwdata[7:0] == FEAT_SEL && supported_q
			&& (enabled_q || sub == SUB_ENABLE) && sub <= SUB_DISABLE;
		if (cmd_wr && cid != ID_ALL && id_to_cond(cid) == C_ACTIVE
			&& (sub == SUB_GOTO || sub == SUB_SET_TIMER || sub == SUB_SET_STATE)) begin
			cmd_ok = 1'b0;
		end
	end

	// Latched configuration inputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			supported_q <= 1'b1;
			wcache_q    <= 1'b0;
			bkg_q       <= 1'b0;
			id120_q     <= 1'b0;
			arg_q       <= 32'h0000_0000;
			tsel_q      <= 3'h0;
		end else begin
			if (wr && paddr == R_CTRL) begin
				supported_q <= pwdata[CT_SUPPORTED];
				wcache_q    <= pwdata[CT_WCACHE];
				bkg_q       <= pwdata[CT_BKG];
				id120_q     <= pwdata[CT_ID120];
			end
			if (wr && paddr == R_ARG) begin
				arg_q <= pwdata;
			end
			if (wr && paddr == R_TSEL) begin
				tsel_q <= pwdata[2:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q <= 32'h0000_0000;
		end else if (tick) begin
			tick_cnt_q <= 32'h0000_0000;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
		end
	end
	assign tick = tick_cnt_q == 32'(TICK_CNT - 1);

	// saved and current settings; defaults are a fixed parameter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NCOND; i++) begin
				cur_q[i]   <= DEF_TIMER;
				saved_q[i] <= DEF_TIMER;
			end
			cur_en_q   <= '1;
			saved_en_q <= '1;
		end else if (ev_pcyc) begin
			for (int i = 0; i < NCOND; i++) begin
				cur_q[i] <= saved_q[i];
			end
			cur_en_q <= saved_en_q;
		end else if (cmd_ok) begin
			for (int i = 0; i < NCOND; i++) begin
				if (cid == ID_ALL || id_to_cond(cid) == 3'(i)) begin
					unique case (sub)
						SUB_RESTORE: begin
							cur_q[i]    <= arg_q[0] ? DEF_TIMER : saved_q[i];
							cur_en_q[i] <= arg_q[0] ? 1'b1 : saved_en_q[i];
							if (arg_q[1] && arg_q[0]) begin
								saved_q[i]    <= DEF_TIMER;
								saved_en_q[i] <= 1'b1;
							end
						end
						SUB_SET_TIMER: begin
							cur_q[i] <= arg_q;
							if (arg_q[1]) begin
								saved_q[i] <= arg_q;
							end
						end
						SUB_SET_STATE: begin
							cur_en_q[i] <= arg_q[0];
							if (arg_q[1]) begin
								saved_en_q[i] <= arg_q[0];
							end
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	// Timer control per condition
	always_comb begin
		for (int i = 0; i < NCOND; i++) begin
			stop_v[i] = ev_act || !enabled_q || !cur_en_q[i];
			load_v[i] = (ev_done || ev_pcyc || ev_rst) && !run_v[i] && cur_en_q[i];
			if (ev_pcyc || ev_rst) begin
				load_v[i] = enabled_q && cur_en_q[i];
			end
		end
	end

	for (genvar g = 0; g < NCOND; g++) begin : g_tmr
		epc_timer u_tmr (
			.pclk    (pclk),
			.presetn (presetn),
			.tick    (tick),
			.stop    (stop_v[g] && !load_v[g]),
			.load    (load_v[g]),
			.pause   (bkg_q),
			.reload  (ev_pcyc ? saved_q[g] : cur_q[g]),
			.count_q (cnt_v[g]),
			.run_q   (run_v[g]),
			.expired (exp_v[g])
		);
	end

	always_comb begin
		exp_pick = C_ACTIVE;
		pick_ok  = 1'b0;
		for (int i = 0; i < NCOND; i++) begin
			if (exp_v[i]) begin
				exp_pick = 3'(i);
				pick_ok  = 1'b1;
			end
		end
	end

	// Feature enable and abort flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enabled_q <= 1'b1;
			abort_q   <= 1'b0;
		end else begin
			if (cmd_wr) begin
				abort_q <= !cmd_ok;
			end
			if (apm_dis) begin
				enabled_q <= 1'b0;
			end else if (cmd_ok && sub == SUB_ENABLE) begin
				enabled_q <= 1'b1;
			end else if (cmd_ok && sub == SUB_DISABLE) begin
				enabled_q <= 1'b0;
			end
		end
	end

	// Present condition, with flush before standby levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cond_q   <= C_ACTIVE;
			target_q <= C_ACTIVE;
			st_q     <= S_RUN;
		end else begin
			unique case (st_q)
				S_RUN: begin
					if (ev_act) begin
						cond_q <= C_ACTIVE;
					end else if ((cmd_ok && sub == SUB_GOTO && cid != ID_ALL)
						|| (pick_ok && (cond_q == C_ACTIVE || exp_pick > cond_q))) begin
						target_q <= (cmd_ok && sub == SUB_GOTO) ? id_to_cond(cid) : exp_pick;
						// flush first when media will be parked
						if (wcache_q && ((cmd_ok && sub == SUB_GOTO)
							? id_to_cond(cid) : exp_pick) >= C_STANDBY_Y) begin
							st_q <= S_FLUSH;
						end else begin
							cond_q <= (cmd_ok && sub == SUB_GOTO) ? id_to_cond(cid) : exp_pick;
						end
					end
				end
				S_FLUSH: begin
					if (ev_act) begin
						st_q   <= S_RUN;
						cond_q <= C_ACTIVE;
					end else if (ctl[CT_FLUSHOK]) begin
						st_q   <= S_RUN;
						cond_q <= target_q;
					end
				end
			endcase
		end
	end

	// Read data; condition grouped into power-management state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= 32'h0000_0000;
			unique case (paddr)
				R_ARG:  prdata <= arg_q;
				R_TSEL: prdata <= {29'h0, tsel_q};
				R_TCUR: prdata <= tsel_q < 3'(NCOND) ? cur_q[tsel_q] : 32'h0000_0000;
				R_TCNT: prdata <= tsel_q < 3'(NCOND) ? cnt_v[tsel_q] : 32'h0000_0000;
				R_STATUS: begin
					prdata[ST_ENABLED]       <= enabled_q;
					prdata[ST_ABORT]         <= abort_q;
					prdata[ST_FLUSH]         <= st_q == S_FLUSH;
					prdata[ST_PMSTATE +: 2]  <= cond_q == C_ACTIVE ? PM_ACTIVE
						: cond_q >= C_STANDBY_Y ? PM_STANDBY : PM_IDLE;
					prdata[ST_COND +: 3]     <= cond_q;
					prdata[ST_RUN +: NCOND]  <= run_v;
				end
				default: begin
				end
			endcase
		end
	end

	// Unused read strobe kept out of logic intentionally
	logic rd_unused;
	assign rd_unused = rd;

	no_raise_a: assert property (@(posedge pclk) disable iff (!presetn)
		(st_q == S_RUN && !ev_act && !cmd_wr && cond_q != C_ACTIVE)
		|=> (cond_q >= $past(cond_q)))
		else $error("condition rose on expiry");

	apm_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
		apm_dis |=> !enabled_q)
		else $error("feature still enabled");

	dis_abort_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cmd_wr && !enabled_q && sub != SUB_ENABLE) |=> abort_q)
		else $error("subcommand not aborted");

	act_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ev_act && !ev_done && !ev_pcyc && !ev_rst) |=> (run_v == '0))
		else $error("timers still running");

	flush_first_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wcache_q && $changed(cond_q) && cond_q >= C_STANDBY_Y && cond_q != C_ACTIVE)
		|-> $past(st_q) == S_FLUSH)
		else $error("standby without flush");

	sel_abort_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cmd_wr && pwdata[7:0] != FEAT_SEL) |=> abort_q)
		else $error("bad selector accepted");

	pause_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(bkg_q && !ev_done && !ev_pcyc && !ev_rst && !ev_act && run_v[0])
		|=> (cnt_v[0] == $past(cnt_v[0])))
		else $error("paused timer moved");

	rst_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ev_rst && !ev_act && st_q == S_RUN && !pick_ok && !cmd_wr)
		|=> cond_q == $past(cond_q))
		else $error("reset changed condition");

endmodule // epc_manager

// ---- verilog/epc_pkg.sv ----
// Constants and types for the extended power-condition manager.
// Assumes a single 10 MHz clock domain and an APB register slave.
package epc_pkg;

	// Configuration subcommand selector and subcommand codes
	localparam logic [7:0] FEAT_SEL      = 8'h4A;
	localparam logic [3:0] SUB_RESTORE   = 4'h0;
	localparam logic [3:0] SUB_GOTO      = 4'h1;
	localparam logic [3:0] SUB_SET_TIMER = 4'h2;
	localparam logic [3:0] SUB_SET_STATE = 4'h3;
	localparam logic [3:0] SUB_ENABLE    = 4'h4;
	localparam logic [3:0] SUB_DISABLE   = 4'h5;

	// Power condition identifiers
	localparam logic [7:0] ID_STANDBY_Z = 8'h00;
	localparam logic [7:0] ID_STANDBY_Y = 8'h01;
	localparam logic [7:0] ID_IDLE_A    = 8'h81;
	localparam logic [7:0] ID_IDLE_B    = 8'h82;
	localparam logic [7:0] ID_IDLE_C    = 8'h83;
	localparam logic [7:0] ID_ALL       = 8'hFF;

	// Condition index; higher index means lower power, except C_ACTIVE (7)
	localparam int NCOND = 5;
	localparam logic [2:0] C_IDLE_A    = 3'h0;
	localparam logic [2:0] C_IDLE_B    = 3'h1;
	localparam logic [2:0] C_IDLE_C    = 3'h2;
	localparam logic [2:0] C_STANDBY_Y = 3'h3;
	localparam logic [2:0] C_STANDBY_Z = 3'h4;
	localparam logic [2:0] C_ACTIVE    = 3'h7;

	// Identify word 120 bit position tested on enable of the older scheme
	localparam int ID_W120_BIT = 7;

	// Timer tick: 100 ms period from a 10 MHz clock
	localparam int CLK_HZ       = 10_000_000;
	localparam int TICK_MS      = 100;
	localparam int TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
	localparam int TMR_W        = 32;

	// Register byte offsets
	localparam logic [11:0] R_CMD      = 12'h000;
	localparam logic [11:0] R_ARG      = 12'h004;
	localparam logic [11:0] R_CTRL     = 12'h008;
	localparam logic [11:0] R_STATUS   = 12'h00C;
	localparam logic [11:0] R_TSEL     = 12'h010;
	localparam logic [11:0] R_TCUR     = 12'h014;
	localparam logic [11:0] R_TCNT     = 12'h018;

	// Bit positions in R_CMD write: [7:0] feature, [11:8] subcommand, [19:12] id
	// R_ARG: [31:0] timer value, [0] state enable, [1] save flag
	// R_CTRL bits (write pulses, except CT_SUPPORTED, CT_WCACHE, CT_ID120 and CT_BKG, which are levels)
	localparam int CT_SUPPORTED = 0;
	localparam int CT_WCACHE    = 1;
	localparam int CT_DONE      = 2;
	localparam int CT_ACTCMD    = 3;
	localparam int CT_POWERCYC  = 4;
	localparam int CT_RESET     = 5;
	localparam int CT_APM_EN    = 6;
	localparam int CT_ID120     = 7;
	localparam int CT_BKG       = 8;
	localparam int CT_FLUSHOK   = 9;

	// Status bits
	localparam int ST_ENABLED = 0;
	localparam int ST_ABORT   = 1;
	localparam int ST_FLUSH   = 2;
	localparam int ST_PMSTATE = 4;  // [5:4]: 0 active, 1 idle, 2 standby
	localparam int ST_COND    = 8;  // [10:8]
	localparam int ST_RUN     = 16; // [20:16]

	localparam logic [1:0] PM_ACTIVE  = 2'h0;
	localparam logic [1:0] PM_IDLE    = 2'h1;
	localparam logic [1:0] PM_STANDBY = 2'h2;

	typedef enum logic [1:0] {S_RUN, S_FLUSH} mgr_t;

	// Map an identifier to a condition index, or C_ACTIVE if not a single one
	function automatic logic [2:0] id_to_cond(input logic [7:0] id);
		unique case (id)
			ID_STANDBY_Z: id_to_cond = C_STANDBY_Z;
			ID_STANDBY_Y: id_to_cond = C_STANDBY_Y;
			ID_IDLE_A:    id_to_cond = C_IDLE_A;
			ID_IDLE_B:    id_to_cond = C_IDLE_B;
			ID_IDLE_C:    id_to_cond = C_IDLE_C;
			default:      id_to_cond = C_ACTIVE;
		endcase
	endfunction

endpackage

// ---- verilog/epc_timer.sv ----
// One idle countdown timer for a single power condition.
// Assumes a shared one-cycle tick pulse from the manager.
`timescale 1ns/1ps
module epc_timer
	import epc_pkg::*;
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             tick,
	input  wire logic             stop,
	input  wire logic             load,
	input  wire logic             pause,
	input  wire logic [TMR_W-1:0] reload,
	output logic      [TMR_W-1:0] count_q,
	output logic                  run_q,
	output logic                  expired
);

	// Start over from the reload value; stop freezes without expiry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= '0;
			run_q   <= 1'b0;
		end else if (stop) begin
			run_q <= 1'b0;
		end else if (load) begin
			count_q <= reload;
			run_q   <= (reload != '0);
		end else if (run_q && tick && !pause) begin
			count_q <= count_q - {{(TMR_W-1){1'b0}}, 1'b1};
			if (count_q == {{(TMR_W-1){1'b0}}, 1'b1}) begin
				run_q <= 1'b0;
			end
		end
	end

	// One-cycle expiry pulse on the last decrement
	assign expired = run_q && tick && !pause && !stop && !load
		&& (count_q == {{(TMR_W-1){1'b0}}, 1'b1});

endmodule // epc_timer

// ---- tb/apb_host.sv ----
// Host-side APB master that drives the power-condition manager's registers.
// Assumes the bench owns reset and calls the tasks only once reset is released.
`timescale 1ns/1ps
module apb_host
	import epc_pkg::*;
(
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	logic [31:0] rdat;
	logic        rerr;

	// Idle bus from time zero
	initial begin
		psel    = 1'h0;
		penable = 1'h0;
		pwrite  = 1'h0;
		paddr   = 12'h000;
		pwdata  = 32'h0000_0000;
	end

	// One transfer; data is inverted after release so stale write data is never reused
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
		pwdata  <= ~d;
	endtask

	task automatic cmd(input logic [3:0] sub, input logic [7:0] id, input logic [31:0] arg);
		xfer(1'h1, R_ARG, arg);
		xfer(1'h1, R_CMD, {12'h000, id, sub, FEAT_SEL});
	endtask
endmodule // apb_host

// ---- tb/ext_power_condition_manager_bench.sv ----
// Self-checking bench for the power-condition manager.
// Assumes a short tick parameter so that idle timers expire within tens of cycles.
`timescale 1ns/1ps
module ext_power_condition_manager_bench import epc_pkg::*;;
	localparam int          TK  = 4;
	localparam logic [31:0] DEF = 32'h0000_000A;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] lvl;
	logic [31:0] sv;
	logic [31:0] rv;
	logic [31:0] a;
	int          fails;
	int          n_checks;
	int          cycles;

	epc_manager #(.TICK_CNT(TK), .DEF_TIMER(DEF)) i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	apb_host i_host (
		.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// 10 MHz clock
	initial begin
		pclk = 1'h0;
		forever #50 pclk = ~pclk;
	end

	// Watchdog, sized well above the expected run of under a thousand cycles
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [11:0] ad);
		i_host.xfer(1'h0, ad, 32'h0000_0000);
		rv = i_host.rdat;
	endtask
	// Level bits are rewritten with every control write
	task automatic ctrl(input logic [31:0] p);
		i_host.xfer(1'h1, R_CTRL, lvl | p);
	endtask
	task automatic rd_st();
		rd(R_STATUS);
		sv = rv;
	endtask
	task automatic cond_is(input logic [2:0] c, input logic [1:0] pm);
		rd_st();
		chk(sv & 32'h0000_0730, {21'h0, c, 2'h0, pm, 4'h0});
	endtask
	task automatic en_ab(input logic e, input logic ab);
		rd_st();
		chk(sv & 32'h0000_0003, {30'h0, ab, e});
	endtask
	task automatic tcur(input int i);
		i_host.xfer(1'h1, R_TSEL, 32'(i));
		rd(R_TCUR);
	endtask
	// Bounded poll until the condition moves away from the old one
	task automatic wait_cond(input logic [2:0] old);
		for (int i = 0; i < 60 && sv[10:8] === old; i++) rd_st();
	endtask
	// Clear all timers, arm chosen ones, then stop and restart them
	task automatic arm(input logic [7:0] id0, input logic [31:0] v0,
			input logic [7:0] id1, input logic [31:0] v1);
		i_host.cmd(SUB_SET_TIMER, ID_ALL, 32'h0000_0000);
		i_host.cmd(SUB_SET_TIMER, id0, v0);
		i_host.cmd(SUB_SET_TIMER, id1, v1);
		ctrl(32'h0000_0008);
		ctrl(32'h0000_0004);
	endtask

	task automatic t_reset();
		rd_st();
		chk(sv, 32'h0000_0701);
		for (int i = 0; i < NCOND; i++) begin
			tcur(i);
			chk(rv, DEF);
		end
		rd(12'h01C);
		chk({31'h0, i_host.rerr}, 32'h0000_0001);
		chk(rv, 32'h0000_0000);
		$display("reset test done");
	endtask

	task automatic t_subs();
		logic [7:0] ids [5];
		ids = '{ID_IDLE_A, ID_IDLE_B, ID_IDLE_C, ID_STANDBY_Y, ID_STANDBY_Z};
		for (int i = 0; i < NCOND; i++) i_host.cmd(SUB_SET_TIMER, ids[i], 32'h10 + 32'(i));
		for (int i = 0; i < NCOND; i++) begin
			tcur(i);
			chk(rv, 32'h10 + 32'(i));
		end
		i_host.cmd(SUB_RESTORE, ID_ALL, 32'h0000_0001);
		tcur(4);
		chk(rv, DEF);
		i_host.cmd(SUB_SET_STATE, ID_IDLE_A, 32'h0000_0001);
		en_ab(1'h1, 1'h0);
		i_host.cmd(SUB_GOTO, ID_IDLE_B, 32'h0000_0000);
		cond_is(C_IDLE_B, PM_IDLE);
		i_host.cmd(SUB_GOTO, ID_STANDBY_Y, 32'h0000_0000);
		cond_is(C_STANDBY_Y, PM_STANDBY);
		i_host.cmd(SUB_DISABLE, ID_ALL, 32'h0000_0000);
		en_ab(1'h0, 1'h0);
		i_host.cmd(SUB_SET_TIMER, ID_IDLE_A, 32'h0000_0003);
		en_ab(1'h0, 1'h1);
		i_host.cmd(SUB_ENABLE, ID_ALL, 32'h0000_0000);
		en_ab(1'h1, 1'h0);
		for (int c = 6; c < 16; c++) begin
			i_host.cmd(4'(c), ID_IDLE_A, 32'h0000_0000);
			en_ab(1'h1, 1'h1);
		end
		i_host.cmd(SUB_SET_TIMER, 8'h02, 32'h0000_0003);
		en_ab(1'h1, 1'h1);
		lvl = 32'h0000_0000;
		ctrl(32'h0000_0000);
		i_host.cmd(SUB_ENABLE, ID_ALL, 32'h0000_0000);
		rd_st();
		chk(sv & 32'h0000_0002, 32'h0000_0002);
		lvl = 32'h0000_0001;
		ctrl(32'h0000_0000);
		$display("subcommand test done");
	endtask

	task automatic t_expire();
		arm(ID_IDLE_A, 32'h0000_0003, ID_IDLE_B, 32'h0000_0000);
		rd_st();
		chk(sv & 32'h001F_0700, 32'h0001_0700);
		wait_cond(C_ACTIVE);
		cond_is(C_IDLE_A, PM_IDLE);
		arm(ID_IDLE_B, 32'h0000_0003, ID_STANDBY_Y, 32'h0000_0003);
		i_host.cmd(SUB_SET_TIMER, ID_IDLE_A, 32'h0000_0008);
		rd_st();
		chk(sv & 32'h001F_0700, 32'h000A_0700);
		wait_cond(C_ACTIVE);
		cond_is(C_STANDBY_Y, PM_STANDBY);
		// Completion restarts all three; the higher-power expiries must not lift the condition
		ctrl(32'h0000_0004);
		repeat (60) @(posedge pclk);
		cond_is(C_STANDBY_Y, PM_STANDBY);
		ctrl(32'h0000_0008);
		rd_st();
		chk(sv & 32'h001F_0700, 32'h0000_0700);
		$display("expiry test done");
	endtask

	task automatic t_flush();
		lvl = 32'h0000_0003;
		arm(ID_STANDBY_Z, 32'h0000_0002, ID_IDLE_A, 32'h0000_0000);
		rd_st();
		for (int i = 0; i < 60 && sv[ST_FLUSH] !== 1'h1; i++) rd_st();
		chk(sv & 32'h0000_0704, 32'h0000_0704);
		ctrl(32'h0000_0200);
		cond_is(C_STANDBY_Z, PM_STANDBY);
		lvl = 32'h0000_0001;
		ctrl(32'h0000_0000);
		$display("flush test done");
	endtask

	task automatic t_pause();
		arm(ID_IDLE_A, 32'h0000_0020, ID_IDLE_B, 32'h0000_0000);
		i_host.xfer(1'h1, R_TSEL, 32'h0000_0000);
		repeat (40) @(posedge pclk);
		lvl = 32'h0000_0101;
		ctrl(32'h0000_0000);
		rd(R_TCNT);
		a = rv;
		repeat (40) @(posedge pclk);
		rd(R_TCNT);
		chk(rv, a);
		lvl = 32'h0000_0001;
		ctrl(32'h0000_0000);
		repeat (12) @(posedge pclk);
		rd(R_TCNT);
		chk(32'(rv < a), 32'h0000_0001);
		$display("pause test done");
	endtask

	task automatic t_resets();
		i_host.cmd(SUB_SET_TIMER, ID_IDLE_A, 32'h0000_0009);
		i_host.cmd(SUB_GOTO, ID_IDLE_B, 32'h0000_0000);
		ctrl(32'h0000_0020);
		cond_is(C_IDLE_B, PM_IDLE);
		chk(sv & 32'h001F_0000, 32'h0001_0000);
		tcur(0);
		chk(rv, 32'h0000_0009);
		// Saved set back to defaults so that a power cycle visibly overwrites current
		i_host.cmd(SUB_RESTORE, ID_ALL, 32'h0000_0003);
		i_host.cmd(SUB_SET_TIMER, ID_IDLE_A, 32'h0000_0009);
		ctrl(32'h0000_0010);
		tcur(0);
		chk(rv, DEF);
		rd_st();
		chk(sv & 32'h001F_0000, 32'h001F_0000);
		$display("reset event test done");
	endtask

	task automatic t_apm();
		ctrl(32'h0000_0040);
		en_ab(1'h1, 1'h0);
		lvl = 32'h0000_0081;
		ctrl(32'h0000_0040);
		rd_st();
		chk(sv & 32'h0000_0001, 32'h0000_0000);
		lvl = 32'h0000_0001;
		ctrl(32'h0000_0000);
		i_host.cmd(SUB_ENABLE, ID_ALL, 32'h0000_0000);
		en_ab(1'h1, 1'h0);
		$display("older scheme test done");
	endtask

	task automatic end_of_test();
		$display("checks=%0d fails=%0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Main sequence: reset for 20 cycles, then each scenario in turn
	initial begin
		presetn = 1'h0;
		lvl = 32'h0000_0001;
		fails = 0;
		n_checks = 0;
		cycles = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		t_reset();
		t_subs();
		t_expire();
		t_flush();
		t_pause();
		t_resets();
		t_apm();
		end_of_test();
	end
endmodule // ext_power_condition_manager_bench
